// file: iout_cal_pkg.sv
// constants shared by the output-current calibration register bank
package iout_cal_pkg;
    localparam logic [7:0]  CMD_GAIN        = 8'h38;
    localparam logic [7:0]  CMD_OFFSET      = 8'h39;
    localparam logic [7:0]  PAGE_A          = 8'h00;
    localparam logic [7:0]  PAGE_B          = 8'h01;
    localparam logic [7:0]  PTR_ALL         = 8'hff;
    localparam logic [7:0]  PHASE_TOTAL     = 8'h80;
    localparam int          NUM_CH          = 2;
    localparam int          NUM_PHASES      = 6;
    localparam int          SLOTS_PER_CH    = NUM_PHASES + 1;
    localparam int          NUM_SLOTS       = NUM_CH * SLOTS_PER_CH;
    localparam logic [2:0]  TOTAL_SLOT      = 3'h6;
    localparam int          EXP_MSB         = 15;
    localparam int          EXP_LSB         = 11;
    localparam int          MAN_W           = 11;
    localparam logic [4:0]  GAIN_EXP        = 5'h1a;
    localparam logic [4:0]  OFFSET_EXP      = 5'h1d;
    localparam logic [15:0] GAIN_MIN        = 16'hd131;
    localparam logic [15:0] GAIN_MAX        = 16'hd150;
    localparam logic [15:0] OFS_ZERO        = 16'he800;
    localparam logic [15:0] OFS_POS_MAX_PH  = 16'he808;
    localparam logic [15:0] OFS_NEG_MIN_PH  = 16'heff9;
    localparam logic [15:0] OFS_NEG_MAX_PH  = 16'hefff;
    localparam logic [15:0] OFS_POS_MAX_TOT = 16'he820;
    localparam logic [15:0] OFS_NEG_MIN_TOT = 16'hefe2;
    localparam logic [15:0] OFS_NEG_MAX_TOT = 16'heffe;
    localparam logic [10:0] GAIN_RST_MAN    = 11'h140;
    localparam logic [10:0] OFS_RST_MAN     = 11'h000;
    localparam int          FRAC_BITS       = 3;
    localparam int          DIV_STEPS       = 19;
    localparam logic [4:0]  DIV_LAST        = 5'h12;
    typedef enum logic [1:0] {
        DIV_IDLE   = 2'b00,
        DIV_RUN    = 2'b01,
        DIV_FINISH = 2'b11
    } div_state_e;
endpackage

// file: cal_check_if.sv
// carries a candidate word to the acceptance checker and its verdict back
`timescale 1ns/10ps
`default_nettype none
interface cal_check_if;
    logic [15:0] word;
    logic        isGain;
    logic        isTotal;
    logic        accept;
    modport chk (input word, input isGain, input isTotal, output accept);
    modport req (output word, output isGain, output isTotal, input accept);
endinterface
`default_nettype wire

// file: cal_code_check.sv
// checks a written word against the accepted code tables
`timescale 1ns/10ps
`default_nettype none
module cal_code_check (
    cal_check_if.chk chk  // word in, verdict out
);
    import iout_cal_pkg::*;
    wire gainOk  = (chk.word >= GAIN_MIN) && (chk.word <= GAIN_MAX);
    wire phaseOk = ((chk.word >= OFS_ZERO) && (chk.word <= OFS_POS_MAX_PH))
                || ((chk.word >= OFS_NEG_MIN_PH) && (chk.word <= OFS_NEG_MAX_PH));
    // total table moves in 0.25 A steps, so odd codes are refused
    wire totalOk = !chk.word[0]
                && (((chk.word >= OFS_ZERO) && (chk.word <= OFS_POS_MAX_TOT))
                 || ((chk.word >= OFS_NEG_MIN_TOT) && (chk.word <= OFS_NEG_MAX_TOT)));
    assign chk.accept = chk.isGain ? gainOk : (chk.isTotal ? totalOk : phaseOk);
endmodule
`default_nettype wire

// file: iout_calibration_regs.sv
// paged and phased current-sense gain and offset trim registers with telemetry scaling
//
// Contract
// - Gain bits 15:11 are read-only and always read the exponent code for -6.
// - Gain writes are accepted only for whole words D131h to D150h.
// - A refused write leaves the register alone and sets the invalid-data and summary flags.
// - A refused write also drives the open-drain alert output active.
// - The offset register is reached only by word reads and writes; other sizes are refused.
// - Page 00h selects channel A, 01h channel B, FFh writes both channels.
// - Phase 00h.. selects single phases, FFh writes all phases, 80h selects the total.
// - Offset bits 15:11 are read-only and always read the exponent code for -3.
// - Offset mantissa is writable, loaded from storage, and checked against the table of its phase kind.
// - Single-phase offsets accept E800h-E808h and EFF9h-EFFFh only.
// - The offset of the measured slot is added to the current readback.
// - Total offsets accept even codes E800h-E820h and EFE2h-EFFEh only.
// - The gain register is word-only and paged and phased like the offset register.
// - The gain of the measured slot divides the sensed voltage to give current.
`timescale 1ns/10ps
`default_nettype none
module iout_calibration_regs (
    input  wire logic        clk,           // 50 MHz clock
    input  wire logic        rst_b,         // async reset, active low
    input  wire logic [7:0]  pagePtr,       // current page pointer
    input  wire logic [7:0]  phasePtr,      // current phase pointer
    input  wire logic        wrStb,         // write command pulse
    input  wire logic        rdStb,         // read command pulse
    input  wire logic [7:0]  cmdCode,       // command code of the access
    input  wire logic        wordXfer,      // access is a word transaction
    input  wire logic [15:0] wrData,        // write word
    output logic      [15:0] rdData_q,      // read word
    output logic             rdValid_q,     // read word valid pulse
    input  wire logic        clearFaults,   // clears the status flags
    output logic             statusCml_q,   // invalid data flag
    output logic             statusWord_q,  // summary communication flag
    output logic             hostAlertOut,  // alert pin output level
    output logic             hostAlertOe_b, // alert pin enable, low drives
    input  wire logic        nvmLoad,       // restore all slots from storage
    input  wire logic [10:0] nvmGainMan,    // stored gain mantissa
    input  wire logic [10:0] nvmOffsetMan,  // stored offset mantissa
    input  wire logic        measStb,       // start of a current conversion
    input  wire logic        measCh,        // channel of the sample
    input  wire logic [2:0]  measSlot,      // phase index, 6 for total
    input  wire logic [15:0] measVolt,      // sensed voltage, 1/64 mV units
    output logic      [15:0] ioutTelem_q,   // current, 0.125 A units, signed
    output logic             ioutValid_q,   // current valid pulse
    output logic             measBusy_q     // conversion in progress
);
    import iout_cal_pkg::*;

    logic [10:0] gainMan_q [NUM_SLOTS];
    logic [10:0] offMan_q  [NUM_SLOTS];

    // access decode
    wire isGainCmd  = (cmdCode == CMD_GAIN);
    wire isOffCmd   = (cmdCode == CMD_OFFSET);
    wire isCalCmd   = isGainCmd || isOffCmd;
    wire pageOk     = (pagePtr == PAGE_A) || (pagePtr == PAGE_B) || (pagePtr == PTR_ALL);
    wire phaseTotal = (phasePtr == PHASE_TOTAL);
    wire phaseOk    = (phasePtr < 8'(NUM_PHASES)) || (phasePtr == PTR_ALL) || phaseTotal;
    wire wrCal      = wrStb && isCalCmd;
    wire rdCal      = rdStb && isCalCmd;

    cal_check_if chkIf ();
    assign chkIf.word    = wrData;
    assign chkIf.isGain  = isGainCmd;
    assign chkIf.isTotal = phaseTotal;
    cal_code_check codeCheck (.chk(chkIf.chk));

    wire wrAccept = wrCal && wordXfer && pageOk && phaseOk && chkIf.accept;
    wire badWrite = wrCal && !wrAccept;
    wire badRead  = rdCal && !wordXfer;
    wire reject   = badWrite || badRead;

    // read slot: broadcast pointers read back channel A / phase 0
    wire       rdChB   = (pagePtr == PAGE_B);
    wire [2:0] rdPh    = phaseTotal ? TOTAL_SLOT : ((phasePtr < 8'(NUM_PHASES)) ? phasePtr[2:0] : 3'h0);
    wire [3:0] rdIdx   = rdChB ? 4'(SLOTS_PER_CH + int'(rdPh)) : {1'b0, rdPh};
    wire [15:0] rdWord = isGainCmd ? {GAIN_EXP, gainMan_q[rdIdx]} : {OFFSET_EXP, offMan_q[rdIdx]};

    // per-slot storage
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : gSlot
        localparam int CH = i / SLOTS_PER_CH;
        localparam int PH = i % SLOTS_PER_CH;
        wire chSel = (pagePtr == PTR_ALL) || (pagePtr == 8'(CH));
        wire phSel = (PH == NUM_PHASES) ? phaseTotal
                                        : ((phasePtr == PTR_ALL) || (phasePtr == 8'(PH)));
        wire hit   = wrAccept && chSel && phSel;
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                gainMan_q[i] <= GAIN_RST_MAN;
                offMan_q[i]  <= OFS_RST_MAN;
            end else if (nvmLoad) begin
                gainMan_q[i] <= nvmGainMan;
                offMan_q[i]  <= nvmOffsetMan;
            end else if (hit) begin
                if (isGainCmd) gainMan_q[i] <= wrData[EXP_LSB-1:0];
                else           offMan_q[i]  <= wrData[EXP_LSB-1:0];
            end
        end
    end

    // read path
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= rdCal && wordXfer;
            if (rdCal && wordXfer) rdData_q <= rdWord;
        end
    end

    // sticky flags: a new fault in the clearing cycle wins
    wire cmlD = reject || (statusCml_q && !clearFaults);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            statusCml_q   <= 1'b0;
            statusWord_q  <= 1'b0;
            hostAlertOut  <= 1'b0;
            hostAlertOe_b <= 1'b1;
        end else begin
            statusCml_q   <= cmlD;
            statusWord_q  <= cmlD;
            hostAlertOut  <= 1'b0;
            hostAlertOe_b <= !cmlD;
        end
    end

    // telemetry: current = volt / gain + offset, serial restoring divide
    div_state_e  divState_q;
    div_state_e  divState_d;
    logic [4:0]  divCnt_q;
    logic [11:0] rem_q;
    logic [18:0] quo_q;
    logic [10:0] divisor_q;
    logic [10:0] offLatch_q;

    wire [3:0]  measIdx  = measCh ? 4'(SLOTS_PER_CH + int'(measSlot)) : {1'b0, measSlot};
    wire        startDiv = measStb && (divState_q == DIV_IDLE);
    wire [11:0] remShift = {rem_q[10:0], quo_q[18]};
    wire        fits     = remShift >= {1'b0, divisor_q};
    wire [11:0] remNext  = fits ? (remShift - {1'b0, divisor_q}) : remShift;
    wire [15:0] offExt   = {{(16-MAN_W){offLatch_q[MAN_W-1]}}, offLatch_q};
    wire [15:0] sumOut   = quo_q[15:0] + offExt;

    always_comb begin
        divState_d = divState_q;
        case (divState_q)
            DIV_IDLE:   if (measStb) divState_d = DIV_RUN;
            DIV_RUN:    if (divCnt_q == DIV_LAST) divState_d = DIV_FINISH;
            DIV_FINISH: divState_d = DIV_IDLE;
            default:    divState_d = DIV_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divState_q <= DIV_IDLE;
            divCnt_q   <= 5'h00;
        end else begin
            divState_q <= divState_d;
            divCnt_q   <= (divState_q == DIV_RUN) ? divCnt_q + 5'h01 : 5'h00;
        end
    end

    // gain range keeps the divisor well away from zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rem_q      <= 12'h000;
            quo_q      <= 19'h00000;
            divisor_q  <= GAIN_RST_MAN;
            offLatch_q <= OFS_RST_MAN;
        end else if (startDiv) begin
            rem_q      <= 12'h000;
            quo_q      <= {measVolt, {FRAC_BITS{1'b0}}};
            divisor_q  <= gainMan_q[measIdx];
            offLatch_q <= offMan_q[measIdx];
        end else if (divState_q == DIV_RUN) begin
            rem_q <= remNext;
            quo_q <= {quo_q[17:0], fits};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ioutTelem_q <= 16'h0000;
            ioutValid_q <= 1'b0;
            measBusy_q  <= 1'b0;
        end else begin
            ioutValid_q <= (divState_q == DIV_FINISH);
            measBusy_q  <= (divState_d != DIV_IDLE);
            if (divState_q == DIV_FINISH) ioutTelem_q <= sumOut;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence badGainWrite;
        wrStb && isGainCmd && (wrData < GAIN_MIN || wrData > GAIN_MAX);
    endsequence
    sequence flagRaised;
        statusCml_q && statusWord_q && !hostAlertOe_b;
    endsequence

    gain_exp_fixed_a: assert property (rdValid_q && $past(isGainCmd)
        |-> rdData_q[EXP_MSB:EXP_LSB] == GAIN_EXP) else $error("gain exponent wrong");
    offset_exp_fixed_a: assert property (rdValid_q && $past(isOffCmd)
        |-> rdData_q[EXP_MSB:EXP_LSB] == OFFSET_EXP) else $error("offset exponent wrong");
    gain_reject_flag_a: assert property (badGainWrite |=> flagRaised)
        else $error("bad gain write not flagged");
    reject_keeps_slot_a: assert property (badWrite && !nvmLoad
        |=> gainMan_q[0] == $past(gainMan_q[0]) && offMan_q[0] == $past(offMan_q[0]))
        else $error("refused write changed a slot");
    alert_until_clear_a: assert property (flagRaised and (!clearFaults && !reject)
        |=> !hostAlertOe_b) else $error("alert dropped early");
    byte_access_reject_a: assert property (wrStb && isOffCmd && !wordXfer
        |=> statusCml_q) else $error("byte write not refused");
    broadcast_page_a: assert property (wrAccept && isOffCmd && pagePtr == PTR_ALL
        && (phasePtr == PAGE_A || phasePtr == PTR_ALL) && !nvmLoad
        |=> offMan_q[0] == $past(wrData[10:0]) && offMan_q[SLOTS_PER_CH] == $past(wrData[10:0]))
        else $error("broadcast page missed a channel");
    total_slot_write_a: assert property (wrAccept && isGainCmd && phaseTotal && pagePtr == PAGE_A
        && !nvmLoad |=> gainMan_q[TOTAL_SLOT] == $past(wrData[10:0]))
        else $error("total slot not written");
    phase_table_a: assert property (wrStb && isOffCmd && !phaseTotal && wrData == 16'he809
        |=> statusCml_q) else $error("out of table offset accepted");
    total_odd_a: assert property (wrStb && isOffCmd && phaseTotal && wrData == 16'he801
        |=> statusCml_q) else $error("odd total offset accepted");
    // result lands 20 edges after the start edge, seen one tick later
    telem_latency_a: assert property (startDiv |=> !ioutValid_q [*8] ##13 ioutValid_q)
        else $error("conversion latency wrong");
endmodule
`default_nettype wire

// file: host_model.sv
// behavioural bus host that issues word and byte trim accesses
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic        clk,           // bus clock
    output logic      [7:0]  pagePtr,       // channel pointer
    output logic      [7:0]  phasePtr,      // phase pointer
    output logic             wrStb,         // write pulse
    output logic             rdStb,         // read pulse
    output logic      [7:0]  cmdCode,       // command code
    output logic             wordXfer,      // word transaction
    output logic      [15:0] wrData,        // write word
    input  wire logic [15:0] rdData_q,      // read word
    input  wire logic        rdValid_q,     // read valid
    input  wire logic        hostAlertOut,  // alert drive level
    input  wire logic        hostAlertOe_b, // alert enable, low drives
    output logic             alertLine      // alert wire seen by host
);
    // released alert wire rises to the pull-up level
    assign alertLine = hostAlertOe_b ? 1'b1 : hostAlertOut;
    initial begin
        {pagePtr, phasePtr, cmdCode} = 24'h000000;
        {wrStb, rdStb, wordXfer} = 3'h0;
        wrData = 16'h0000;
    end
    task automatic put(input logic [7:0] pg, input logic [7:0] ph, input logic [7:0] cmd, input logic wd);
        @(negedge clk);
        pagePtr  = pg;
        phasePtr = ph;
        cmdCode  = cmd;
        wordXfer = wd;
    endtask
    task automatic wr(input logic [7:0] pg, ph, cmd, input logic wd, input logic [15:0] d);
        put(pg, ph, cmd, wd);
        wrData = d;
        wrStb  = 1'b1;
        @(negedge clk);
        wrStb  = 1'b0;
        // stale data must not pass for a fresh write
        wrData = ~d;
    endtask
    task automatic rd(input logic [7:0] pg, ph, cmd, input logic wd, output logic v, output logic [15:0] d);
        put(pg, ph, cmd, wd);
        rdStb = 1'b1;
        @(negedge clk);
        rdStb = 1'b0;
        v = rdValid_q;
        d = rdData_q;
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the calibration trim registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import iout_cal_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clearFaults = 1'b0;
    logic        nvmLoad = 1'b0;
    logic [10:0] nvmGainMan = 11'h140;
    logic [10:0] nvmOffsetMan = 11'h000;
    logic        measStb = 1'b0;
    logic        measCh = 1'b0;
    logic [2:0]  measSlot = 3'h0;
    logic [15:0] measVolt = 16'h2800;
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          n;
    logic        v;
    logic [15:0] d;
    wire logic [7:0]  pagePtr, phasePtr, cmdCode;
    wire logic [15:0] wrData, rdData_q, ioutTelem_q;
    wire logic        wrStb, rdStb, wordXfer, rdValid_q, statusCml_q, statusWord_q;
    wire logic        hostAlertOut, hostAlertOe_b, alertLine, ioutValid_q, measBusy_q;
    always #10 clk = ~clk;
    iout_calibration_regs dut (.clk(clk), .rst_b(rst_b), .pagePtr(pagePtr), .phasePtr(phasePtr),
        .wrStb(wrStb), .rdStb(rdStb), .cmdCode(cmdCode), .wordXfer(wordXfer), .wrData(wrData),
        .rdData_q(rdData_q), .rdValid_q(rdValid_q), .clearFaults(clearFaults),
        .statusCml_q(statusCml_q), .statusWord_q(statusWord_q), .hostAlertOut(hostAlertOut),
        .hostAlertOe_b(hostAlertOe_b), .nvmLoad(nvmLoad), .nvmGainMan(nvmGainMan),
        .nvmOffsetMan(nvmOffsetMan), .measStb(measStb), .measCh(measCh), .measSlot(measSlot),
        .measVolt(measVolt), .ioutTelem_q(ioutTelem_q), .ioutValid_q(ioutValid_q), .measBusy_q(measBusy_q));
    host_model host (.clk(clk), .pagePtr(pagePtr), .phasePtr(phasePtr), .wrStb(wrStb), .rdStb(rdStb),
        .cmdCode(cmdCode), .wordXfer(wordXfer), .wrData(wrData), .rdData_q(rdData_q),
        .rdValid_q(rdValid_q), .hostAlertOut(hostAlertOut), .hostAlertOe_b(hostAlertOe_b),
        .alertLine(alertLine));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic rdChk(input logic [7:0] pg, ph, cmd, input logic [15:0] e);
        host.rd(pg, ph, cmd, 1'b1, v, d);
        chkBit("rdValid", 1'b1, v);
        chk("rdData", e, d);
    endtask
    // flags are sticky, so each refusal is cleared before the next one
    task automatic refuse(input logic [7:0] pg, ph, cmd, input logic wd, input logic [15:0] dat);
        host.wr(pg, ph, cmd, wd, dat);
        chkBit("statusCml", 1'b1, statusCml_q);
        chkBit("statusWord", 1'b1, statusWord_q);
        chkBit("alertLine", 1'b0, alertLine);
        @(negedge clk);
        chkBit("alertHeld", 1'b0, alertLine);
        clearFaults = 1'b1;
        @(negedge clk);
        clearFaults = 1'b0;
        chkBit("alertCleared", 1'b1, alertLine);
    endtask
    task automatic accept(input logic [7:0] pg, ph, cmd, input logic [15:0] dat);
        host.wr(pg, ph, cmd, 1'b1, dat);
        chkBit("noFault", 1'b0, statusCml_q);
        rdChk(pg, ph, cmd, dat);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        rdChk(PAGE_A, 8'h00, CMD_GAIN, 16'hd140);
        rdChk(PAGE_B, 8'h05, CMD_OFFSET, 16'he800);
        $display("test reset done");
        accept(PAGE_A, 8'h00, CMD_GAIN, 16'hd131);
        accept(PAGE_A, 8'h00, CMD_GAIN, 16'hd150);
        refuse(PAGE_A, 8'h00, CMD_GAIN, 1'b1, 16'hd130);
        refuse(PAGE_A, 8'h00, CMD_GAIN, 1'b1, 16'hd151);
        rdChk(PAGE_A, 8'h00, CMD_GAIN, 16'hd150);
        $display("test gain table done");
        accept(PAGE_A, 8'h01, CMD_OFFSET, 16'he808);
        accept(PAGE_A, 8'h01, CMD_OFFSET, 16'heff9);
        accept(PAGE_A, 8'h01, CMD_OFFSET, 16'hefff);
        refuse(PAGE_A, 8'h01, CMD_OFFSET, 1'b1, 16'he809);
        refuse(PAGE_A, 8'h01, CMD_OFFSET, 1'b1, 16'heff8);
        rdChk(PAGE_A, 8'h01, CMD_OFFSET, 16'hefff);
        accept(PAGE_A, PHASE_TOTAL, CMD_OFFSET, 16'he820);
        accept(PAGE_A, PHASE_TOTAL, CMD_OFFSET, 16'hefe2);
        refuse(PAGE_A, PHASE_TOTAL, CMD_OFFSET, 1'b1, 16'he801);
        refuse(PAGE_A, PHASE_TOTAL, CMD_OFFSET, 1'b1, 16'he822);
        accept(PAGE_B, PHASE_TOTAL, CMD_GAIN, 16'hd13d);
        accept(PAGE_A, PHASE_TOTAL, CMD_GAIN, 16'hd132);
        $display("test offset tables done");
        host.wr(PTR_ALL, PTR_ALL, CMD_OFFSET, 1'b1, 16'heffc);
        rdChk(PAGE_B, 8'h04, CMD_OFFSET, 16'heffc);
        rdChk(PAGE_A, 8'h00, CMD_OFFSET, 16'heffc);
        rdChk(PAGE_A, PHASE_TOTAL, CMD_OFFSET, 16'hefe2);
        refuse(8'h02, 8'h00, CMD_OFFSET, 1'b1, 16'he800);
        refuse(PAGE_A, 8'h40, CMD_GAIN, 1'b1, 16'hd140);
        refuse(PAGE_A, 8'h00, CMD_GAIN, 1'b0, 16'hd140);
        refuse(PAGE_A, 8'h00, CMD_OFFSET, 1'b0, 16'he800);
        host.rd(PAGE_A, 8'h00, CMD_OFFSET, 1'b0, v, d);
        chkBit("byteRead", 1'b0, v);
        chkBit("byteReadFlag", 1'b1, statusCml_q);
        // sticky flag would spoil the next accepted write
        clearFaults = 1'b1;
        @(negedge clk);
        clearFaults = 1'b0;
        $display("test pointers and sizes done");
        accept(PAGE_A, 8'h00, CMD_GAIN, 16'hd13d);
        @(negedge clk);
        measStb = 1'b1;
        @(negedge clk);
        measStb = 1'b0;
        chkBit("measBusy", 1'b1, measBusy_q);
        n = 1;
        while (ioutValid_q !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("latency", 16'h0015, 16'(n));
        // floor of 0x2800*8/0x13d is 0x102, less the 0.5 A offset
        chk("iout", 16'h00fe, ioutTelem_q);
        $display("test telemetry done");
        nvmGainMan = 11'h13f;
        nvmOffsetMan = 11'h7ff;
        @(negedge clk);
        nvmLoad = 1'b1;
        @(negedge clk);
        nvmLoad = 1'b0;
        rdChk(PAGE_B, 8'h03, CMD_GAIN, 16'hd13f);
        rdChk(PAGE_B, 8'h03, CMD_OFFSET, 16'hefff);
        $display("test storage reload done");
        finish_test();
    end
endmodule
`default_nettype wire
